// File: design/aach_axis_aux_command_handler.sv
// Purpose: command interpreter for auxiliary axis commands, Avalon-MM slave
// Assumes: motion core on clk_sys drives busy, fault and count inputs
// Notes:   one wait state per access; command writes stall while busy
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module aach_axis_aux_command_handler
    import aach_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 module_error,
    input  wire logic [AXES-1:0]      axis_operating,
    input  wire logic [AXES-1:0]      fault_set,
    input  wire logic [AXES-1:0]      fault_inhibit,
    input  wire logic [15:0]          fault_code,
    input  wire logic [AXES-1:0]      enc_up,
    input  wire logic [AXES-1:0]      enc_dn,
    input  wire logic [AXES-1:0]      pos_up,
    input  wire logic [AXES-1:0]      pos_dn,
    input  wire logic [AXES-1:0]      aux_code_set,
    input  wire logic [15:0]          aux_code_in,
    output logic                      module_ready,
    output logic                      cmd_done,
    output logic      [15:0]          cmd_stat,
    output logic      [AXES-1:0]      output_inhibit,
    output logic      [AXES-1:0]      aux_code_on,
    output logic      [31:0]          enc_count_x,
    output logic      [31:0]          enc_count_y,
    output logic      [31:0]          cur_pos_x,
    output logic      [31:0]          cur_pos_y
);

    // byte-lane merge used by every writable word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction
    // up/down count step shared by encoder and position counters
    function automatic logic [31:0] step(input logic [31:0] v,
                                         input logic        up,
                                         input logic        dn);
        if (up == dn) begin
            return v;
        end
        return up ? v + 32'h1 : v - 32'h1;
    endfunction
    // bus handshake state
    logic                 ack_r;
    logic                 ack_nxt;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;

    // software-visible configuration
    logic [31:0]          cmd_word_r;
    logic [31:0]          cmd_word_nxt;
    logic [31:0]          arg_r;
    logic [31:0]          arg_nxt;
    logic [31:0]          aux_mode_r;
    logic [31:0]          aux_mode_nxt;
    logic [31:0]          home_r     [AXES];
    logic [31:0]          home_nxt   [AXES];

    // command engine state
    aach_state_t          state_r;
    aach_state_t          state_nxt;
    logic                 done_r;
    logic                 done_nxt;
    logic [15:0]          stat_r;
    logic [15:0]          stat_nxt;
    logic                 ready_r;
    logic                 ready_nxt;
    // per-axis state
    logic                 err_r      [AXES];
    logic                 err_nxt    [AXES];
    logic [15:0]          err_code_r [AXES];
    logic [15:0]          err_code_nxt [AXES];
    logic                 inh_r      [AXES];
    logic                 inh_nxt    [AXES];
    logic [31:0]          enc_r      [AXES];
    logic [31:0]          enc_nxt    [AXES];
    logic [31:0]          pos_r      [AXES];
    logic [31:0]          pos_nxt    [AXES];
    logic                 aux_on_r   [AXES];
    logic                 aux_on_nxt [AXES];
    logic [15:0]          aux_num_r  [AXES];
    logic [15:0]          aux_num_nxt [AXES];

    logic                 access;
    logic                 cmd_hit;
    logic                 wr_fire;
    logic [3:0]           cmd_code;
    logic [3:0]           cmd_axis;
    logic                 cmd_inh;
    logic                 axis_ok;
    logic                 sel;

    assign access   = avs_read | avs_write;
    assign cmd_hit  = (avs_address == OFS_CMD);
    assign wr_fire  = avs_write & ack_r;
    assign cmd_code = cmd_word_r[CMD_CODE_LSB +: 4];
    assign cmd_axis = cmd_word_r[CMD_AXIS_LSB +: 4];
    assign cmd_inh  = cmd_word_r[CMD_INH_BIT];
    assign axis_ok  = (cmd_axis < 4'(AXES));
    assign sel      = cmd_axis[0];

    // one wait state; a command write is held off until idle
    assign avs_waitrequest = access & ~ack_r;

    // bus handshake and read data
    always_comb begin
        logic [5:0] w;
        logic       ax;
        w         = 6'h00;
        ax        = 1'b0;
        ack_nxt   = access & ~ack_r
                    & ~(avs_write & cmd_hit & (state_r != AACH_IDLE));
        rdata_nxt = rdata_r;
        if (avs_read && ack_nxt) begin
            rdata_nxt = ZERO32;
            if (avs_address[9:6] == OFS_STATE_X[9:6]
                || avs_address[9:6] == OFS_STATE_Y[9:6]) begin
                ax = (avs_address[9:6] == OFS_STATE_Y[9:6]);
                w  = avs_address[5:0];
                case (w)
                    SW_FLAGS: begin
                        rdata_nxt[FLAG_OPER] = axis_operating[ax];
                        rdata_nxt[FLAG_ERR]  = err_r[ax];
                    end
                    SW_ERR_CODE: rdata_nxt[15:0] = err_code_r[ax];
                    SW_ENC_LO:   rdata_nxt[15:0] = enc_r[ax][15:0];
                    SW_ENC_HI:   rdata_nxt[15:0] = enc_r[ax][31:16];
                    SW_POS_LO:   rdata_nxt[15:0] = pos_r[ax][15:0];
                    SW_POS_HI:   rdata_nxt[15:0] = pos_r[ax][31:16];
                    SW_AUX_NUM:  rdata_nxt[15:0] = aux_num_r[ax];
                    default:     rdata_nxt = ZERO32;
                endcase
            end else begin
                case (avs_address)
                    OFS_CMD:      rdata_nxt = cmd_word_r;
                    OFS_ARG:      rdata_nxt = arg_r;
                    OFS_STATUS: begin
                        rdata_nxt[ST_READY_BIT] = ready_r;
                        rdata_nxt[ST_DONE_BIT]  = done_r;
                        rdata_nxt[ST_BUSY_BIT]  = (state_r != AACH_IDLE);
                        rdata_nxt[ST_STAT_LSB +: 16] = stat_r;
                    end
                    OFS_AUX_MODE: rdata_nxt = aux_mode_r;
                    OFS_HOME_X:   rdata_nxt = home_r[0];
                    OFS_HOME_Y:   rdata_nxt = home_r[1];
                    default:      rdata_nxt = ZERO32;  // unmapped reads zero
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_r   <= 1'b0;
            rdata_r <= ZERO32;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // configuration registers, written at the edge waitrequest is low
    always_comb begin
        cmd_word_nxt = cmd_word_r;
        arg_nxt      = arg_r;
        aux_mode_nxt = aux_mode_r;
        home_nxt     = home_r;
        if (wr_fire) begin
            case (avs_address)
                OFS_CMD:      cmd_word_nxt =
                    be_merge(cmd_word_r, avs_writedata, avs_byteenable);
                OFS_ARG:      arg_nxt =
                    be_merge(arg_r, avs_writedata, avs_byteenable);
                OFS_AUX_MODE: aux_mode_nxt =
                    be_merge(aux_mode_r, avs_writedata, avs_byteenable);
                OFS_HOME_X:   home_nxt[0] =
                    be_merge(home_r[0], avs_writedata, avs_byteenable);
                OFS_HOME_Y:   home_nxt[1] =
                    be_merge(home_r[1], avs_writedata, avs_byteenable);
                default:      ;  // unmapped writes are dropped
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_word_r <= ZERO32;
            arg_r      <= ZERO32;
            aux_mode_r <= ZERO32;
            home_r     <= '{default: ZERO32};
        end else begin
            cmd_word_r <= cmd_word_nxt;
            arg_r      <= arg_nxt;
            aux_mode_r <= aux_mode_nxt;
            home_r     <= home_nxt;
        end
    end

    // command engine and per-axis state; hardware events win over clears
    always_comb begin
        logic clr_fault;
        logic aux_rel;
        logic [1:0] mode;
        clr_fault = 1'b0;
        aux_rel   = 1'b0;
        mode      = 2'h0;
        state_nxt = state_r;
        done_nxt  = done_r;
        stat_nxt  = stat_r;
        // ready drops for good on a module error
        ready_nxt = ready_r & ~module_error;
        for (int a = 0; a < AXES; a++) begin
            err_nxt[a]      = err_r[a];
            err_code_nxt[a] = err_code_r[a];
            inh_nxt[a]      = inh_r[a];
            enc_nxt[a]      = step(enc_r[a], enc_up[a], enc_dn[a]);
            pos_nxt[a]      = step(pos_r[a], pos_up[a], pos_dn[a]);
            aux_on_nxt[a]   = aux_on_r[a];
            aux_num_nxt[a]  = aux_num_r[a];
        end
        case (state_r)
            AACH_IDLE: begin
                if (wr_fire && cmd_hit) begin
                    state_nxt = AACH_EXEC;
                end
            end
            AACH_EXEC: begin
                state_nxt = AACH_IDLE;
                done_nxt  = 1'b1;
                stat_nxt  = ERR_NONE;
                if (!axis_ok) begin
                    stat_nxt = ERR_AXIS;
                end else begin
                    case (cmd_code)
                        AACH_CMD_PRESET: begin
                            enc_nxt[sel] = arg_r & PRESET_MASK;
                        end
                        AACH_CMD_CLEAR: begin
                            clr_fault = 1'b1;
                        end
                        AACH_CMD_FLOAT: begin
                            if (axis_operating[sel]) begin
                                stat_nxt = ERR_FLOAT_RUN;
                            end else begin
                                pos_nxt[sel] = home_r[sel];
                            end
                        end
                        AACH_CMD_AUX_REL: begin
                            mode = aux_mode_r[sel*AUX_MODE_STEP +: 2];
                            aux_rel = (mode == AACH_AUX_WITH)
                                      || (mode == AACH_AUX_AFTER);
                        end
                        default: stat_nxt = ERR_BAD_CMD;
                    endcase
                end
                if (clr_fault) begin
                    err_nxt[sel]      = 1'b0;
                    err_code_nxt[sel] = ERR_NONE;
                    inh_nxt[sel] = inh_r[sel] & ~cmd_inh;
                end
                if (aux_rel) begin
                    aux_on_nxt[sel]  = 1'b0;
                    aux_num_nxt[sel] = 16'h0000;
                end
            end
            default: state_nxt = AACH_IDLE;
        endcase
        // events from the motion core land after any clear
        for (int a = 0; a < AXES; a++) begin
            if (fault_set[a]) begin
                err_nxt[a]      = 1'b1;
                err_code_nxt[a] = fault_code;
                if (fault_inhibit[a]) begin
                    inh_nxt[a] = 1'b1;
                end
            end
            if (aux_code_set[a]) begin
                aux_on_nxt[a]  = 1'b1;
                aux_num_nxt[a] = aux_code_in;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= AACH_IDLE;
            done_r  <= 1'b0;
            stat_r  <= ERR_NONE;
            ready_r <= 1'b1;
            for (int a = 0; a < AXES; a++) begin
                err_r[a]      <= 1'b0;
                err_code_r[a] <= ERR_NONE;
                inh_r[a]      <= 1'b0;
                enc_r[a]      <= ZERO32;
                pos_r[a]      <= ZERO32;
                aux_on_r[a]   <= 1'b0;
                aux_num_r[a]  <= 16'h0000;
            end
        end else begin
            state_r <= state_nxt;
            done_r  <= done_nxt;
            stat_r  <= stat_nxt;
            ready_r <= ready_nxt;
            for (int a = 0; a < AXES; a++) begin
                err_r[a]      <= err_nxt[a];
                err_code_r[a] <= err_code_nxt[a];
                inh_r[a]      <= inh_nxt[a];
                enc_r[a]      <= enc_nxt[a];
                pos_r[a]      <= pos_nxt[a];
                aux_on_r[a]   <= aux_on_nxt[a];
                aux_num_r[a]  <= aux_num_nxt[a];
            end
        end
    end
    // outputs straight from flip-flops, except module_ready, which is also gated by module_error
    assign avs_readdata   = rdata_r;
    assign module_ready   = ready_r & ~module_error;
    assign cmd_done       = done_r;
    assign cmd_stat       = stat_r;
    assign output_inhibit = {inh_r[1], inh_r[0]};
    assign aux_code_on    = {aux_on_r[1], aux_on_r[0]};
    assign enc_count_x    = enc_r[0];
    assign enc_count_y    = enc_r[1];
    assign cur_pos_x      = pos_r[0];
    assign cur_pos_y      = pos_r[1];

endmodule // aach_axis_aux_command_handler

// File: design/aach_pkg.sv
// Purpose: constants for the two-axis auxiliary command handler
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes:   axis state blocks sit at a fixed stride from the first block
package aach_pkg;
    localparam int          AXES          = 2;
    localparam int          ADDR_W        = 10;
    // register byte offsets
    localparam logic [9:0]  OFS_CMD       = 10'h000;
    localparam logic [9:0]  OFS_ARG       = 10'h004;
    localparam logic [9:0]  OFS_STATUS    = 10'h008;
    localparam logic [9:0]  OFS_AUX_MODE  = 10'h00c;
    localparam logic [9:0]  OFS_HOME_X    = 10'h010;
    localparam logic [9:0]  OFS_HOME_Y    = 10'h014;
    localparam logic [9:0]  OFS_STATE_X   = 10'h140;
    localparam logic [9:0]  OFS_STATE_Y   = 10'h180;
    // byte offsets of the words inside one axis state block
    localparam logic [5:0]  SW_FLAGS      = 6'h00;
    localparam logic [5:0]  SW_ERR_CODE   = 6'h04;
    localparam logic [5:0]  SW_ENC_LO     = 6'h08;
    localparam logic [5:0]  SW_ENC_HI     = 6'h0c;
    localparam logic [5:0]  SW_POS_LO     = 6'h10;
    localparam logic [5:0]  SW_POS_HI     = 6'h14;
    localparam logic [5:0]  SW_AUX_NUM    = 6'h18;
    // state word flag positions
    localparam int          FLAG_OPER     = 0;
    localparam int          FLAG_ERR      = 1;
    // command register fields
    localparam int          CMD_CODE_LSB  = 0;
    localparam int          CMD_AXIS_LSB  = 8;
    localparam int          CMD_INH_BIT   = 16;
    // status register fields
    localparam int          ST_READY_BIT  = 0;
    localparam int          ST_DONE_BIT   = 1;
    localparam int          ST_BUSY_BIT   = 2;
    localparam int          ST_STAT_LSB   = 16;
    // aux mode field stride per axis; 2-bit fields packed at 4-bit stride
    localparam int          AUX_MODE_STEP = 4;
    // error numbers
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] ERR_AXIS      = 16'h0006;
    localparam logic [15:0] ERR_FLOAT_RUN = 16'h00d4;
    localparam logic [15:0] ERR_BAD_CMD   = 16'h0001;
    localparam logic [31:0] PRESET_MASK   = 32'h7fff_ffff;
    localparam logic [31:0] ZERO32        = 32'h0000_0000;

    typedef enum logic [3:0] {
        AACH_CMD_NONE    = 4'h0,
        AACH_CMD_PRESET  = 4'h1,
        AACH_CMD_CLEAR   = 4'h2,
        AACH_CMD_FLOAT   = 4'h3,
        AACH_CMD_AUX_REL = 4'h4
    } aach_cmd_t;

    typedef enum logic [1:0] {
        AACH_AUX_NONE  = 2'h0,
        AACH_AUX_WITH  = 2'h1,
        AACH_AUX_AFTER = 2'h2
    } aach_aux_mode_t;

    typedef enum {AACH_IDLE, AACH_EXEC} aach_state_t;
endpackage

// File: verification/aach_asserts.sv
// Purpose: port assertions for the auxiliary command handler
// Assumes: one command at a time
// Notes:   shadow copies give exact expectations
`timescale 1ns/10ps
module aach_checker
    import aach_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic              avs_waitrequest,
    input wire logic              module_error,
    input wire logic [AXES-1:0]   axis_operating,
    input wire logic              module_ready,
    input wire logic              cmd_done,
    input wire logic [15:0]       cmd_stat,
    input wire logic [AXES-1:0]   output_inhibit,
    input wire logic [AXES-1:0]   aux_code_on,
    input wire logic [31:0]       enc_count_x,
    input wire logic [31:0]       cur_pos_x
);
    logic        wr_ok;
    logic        cmd_w;
    logic        cmd_x;
    logic [3:0]  code;
    logic [31:0] arg_r;
    logic [31:0] home_r;
    logic [1:0]  mode_r;
    // accepted writes; command aimed at axis X
    assign wr_ok = avs_write & ~avs_waitrequest;
    assign cmd_w = wr_ok && avs_address == OFS_CMD;
    assign cmd_x = cmd_w && avs_writedata[11:8] == 4'h0;
    assign code  = avs_writedata[3:0];
    // shadow copies of written words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arg_r  <= ZERO32;
            home_r <= ZERO32;
            mode_r <= 2'h0;
        end else if (wr_ok) begin
            if (avs_address == OFS_ARG) arg_r <= avs_writedata;
            if (avs_address == OFS_HOME_X) home_r <= avs_writedata;
            if (avs_address == OFS_AUX_MODE) mode_r <= avs_writedata[1:0];
        end
    end

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_preset_loads: assert property (cmd_x && code == 4'h1
        |=> ##1 enc_count_x == (arg_r & PRESET_MASK))
        else $error("preset value not loaded");
    a_axis_range: assert property (cmd_w && avs_writedata[11:8] > 4'h1
        |=> ##1 cmd_stat == ERR_AXIS)
        else $error("bad axis not reported");
    a_float_refused: assert property (
        cmd_x && code == 4'h3 && axis_operating[0]
        |=> ##1 cmd_stat == ERR_FLOAT_RUN && $stable(cur_pos_x))
        else $error("float home while running not refused");
    a_float_home: assert property (
        cmd_x && code == 4'h3 && !axis_operating[0]
        |=> ##1 cur_pos_x == home_r)
        else $error("home address not loaded");
    a_inhibit_kept: assert property (
        cmd_x && code == 4'h2 && !avs_writedata[16] && output_inhibit[0]
        |=> ##1 output_inhibit[0])
        else $error("inhibition lifted without cancel");
    a_inhibit_lift: assert property (
        cmd_x && code == 4'h2 && avs_writedata[16]
        |=> ##1 !output_inhibit[0])
        else $error("inhibition not lifted");
    a_aux_release: assert property (
        cmd_x && code == 4'h4 && mode_r != 2'h0 |=> ##1 !aux_code_on[0])
        else $error("aux signal not released");
    a_done_sticky: assert property (cmd_w |=> ##1 cmd_done [*3])
        else $error("done not held after command");
    a_ready_error: assert property (module_error |=> !module_ready)
        else $error("ready while module error");
    a_ready_stays: assert property ($past(rst_n) && $fell(module_error)
        |-> !module_ready)
        else $error("ready came back without reset");
    a_wait_first: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest)
        else $error("request answered without wait cycle");

    c_float: cover property (cmd_x && code == 4'h3);
    c_lift: cover property (cmd_x && avs_writedata[16]);
    c_error: cover property (module_error);
endmodule // aach_checker

bind aach_axis_aux_command_handler aach_checker chk_u (.clk_sys, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
    .module_error, .axis_operating, .module_ready, .cmd_done, .cmd_stat,
    .output_inhibit, .aux_code_on, .enc_count_x, .cur_pos_x);

// File: verification/aach_axis_aux_command_handler_bench.sv
// Purpose: self-checking bench for the auxiliary command handler
// Assumes: ctrl_u makes all bus traffic; motion inputs driven here
// Notes:   counts move only by command
`timescale 1ns/10ps
module aach_axis_aux_command_handler_bench;
    import aach_pkg::*;
    logic              clk_sys;
    logic              rst_n          = 1'b0;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              module_error   = 1'b0;
    logic [AXES-1:0]   axis_operating = '0;
    logic [AXES-1:0]   fault_set      = '0;
    logic [AXES-1:0]   fault_inhibit  = '0;
    logic [15:0]       fault_code     = '0;
    logic [AXES-1:0]   aux_code_set   = '0;
    logic [15:0]       aux_code_in    = '0;
    logic              module_ready;
    logic              cmd_done;
    logic [15:0]       cmd_stat;
    logic [AXES-1:0]   output_inhibit;
    logic [AXES-1:0]   aux_code_on;
    logic [31:0]       enc_count_x;
    logic [31:0]       enc_count_y;
    logic [31:0]       cur_pos_x;
    logic [31:0]       q;
    int                failures       = 0;
    int                comparisons    = 0;
    int                cycles         = 0;

    aach_axis_aux_command_handler dut_u (.clk_sys, .rst_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .module_error, .axis_operating,
        .fault_set, .fault_inhibit, .fault_code, .enc_up(2'h0),
        .enc_dn(2'h0), .pos_up(2'h0), .pos_dn(2'h0), .aux_code_set,
        .aux_code_in, .module_ready, .cmd_done, .cmd_stat, .output_inhibit,
        .aux_code_on, .enc_count_x, .enc_count_y, .cur_pos_x, .cur_pos_y());
    aach_ctrl_model ctrl_u (.clk_sys, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard, far above the run's length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        ctrl_u.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [9:0] a);
        ctrl_u.xfer(1'b0, a, ZERO32, q);
    endtask
    function automatic logic [31:0] cw(input logic [3:0] c,
                                       input logic [3:0] a, input logic i);
        return {15'h0000, i, 4'h0, a, 4'h0, c};
    endfunction

    task automatic t_reset();
        chk("ready", 32'h1, module_ready);
        chk("done", 32'h0, cmd_done);
        rd(10'h3fc);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic t_preset();
        wr(OFS_ARG, 32'hffff_ffff);
        ctrl_u.cmd(cw(4'h1, 4'h0, 1'b0));
        chk("enc_x", 32'h7fff_ffff, enc_count_x);
        chk("done", 32'h1, cmd_done);
        wr(OFS_ARG, 32'h1234_5678);
        ctrl_u.cmd(cw(4'h1, 4'h1, 1'b0));
        chk("enc_y", 32'h1234_5678, enc_count_y);
        chk("enc_x_kept", 32'h7fff_ffff, enc_count_x);
        rd(10'h140 + 10'(SW_ENC_LO));
        chk("x_enc_lo", 32'h0000_ffff, q);
        rd(OFS_STATE_Y + 10'(SW_ENC_HI));
        chk("y_enc_hi", 32'h0000_1234, q);
    endtask
    task automatic t_bad_axis();
        ctrl_u.cmd(cw(4'h1, 4'h2, 1'b0));
        chk("stat_ax2", 32'(ERR_AXIS), cmd_stat);
        ctrl_u.cmd(cw(4'h1, 4'hf, 1'b0));
        chk("stat_axf", 32'(ERR_AXIS), cmd_stat);
        chk("enc_x_kept", 32'h7fff_ffff, enc_count_x);
    endtask
    task automatic t_clear();
        @(posedge clk_sys);
        fault_set     <= 2'h1;
        fault_inhibit <= 2'h1;
        fault_code    <= 16'h0123;
        @(posedge clk_sys);
        fault_set     <= 2'h0;
        fault_inhibit <= 2'h0;
        rd(OFS_STATE_X + 10'(SW_FLAGS));
        chk("flags_err", 32'h2, q);
        ctrl_u.cmd(cw(4'h2, 4'h0, 1'b0));
        chk("inh_kept", 32'h1, output_inhibit);
        rd(OFS_STATE_X + 10'(SW_FLAGS));
        chk("flags_clr", 32'h0, q);
        ctrl_u.cmd(cw(4'h2, 4'h0, 1'b1));
        chk("inh_lift", 32'h0, output_inhibit);
    endtask
    task automatic t_float();
        wr(OFS_HOME_X, 32'h0000_0abc);
        @(posedge clk_sys);
        axis_operating <= 2'h1;
        rd(OFS_STATE_X + 10'(SW_FLAGS));
        chk("flags_op", 32'h1, q);
        ctrl_u.cmd(cw(4'h3, 4'h0, 1'b0));
        chk("stat_run", 32'(ERR_FLOAT_RUN), cmd_stat);
        chk("pos_kept", 32'h0, cur_pos_x);
        @(posedge clk_sys);
        axis_operating <= 2'h0;
        ctrl_u.cmd(cw(4'h3, 4'h0, 1'b0));
        chk("pos_home", 32'h0000_0abc, cur_pos_x);
        chk("stat_ok", 32'h0, cmd_stat);
    endtask
    task automatic t_aux();
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_sys);
            aux_code_set <= 2'h1;
            aux_code_in  <= 16'h0031;
            @(posedge clk_sys);
            aux_code_set <= 2'h0;
            wr(OFS_AUX_MODE, 32'(m));
            ctrl_u.cmd(cw(4'h4, 4'h0, 1'b0));
            chk("aux_on", (m == 0) ? 32'h1 : 32'h0, aux_code_on);
            rd(OFS_STATE_X + 10'(SW_AUX_NUM));
            chk("aux_num", (m == 0) ? 32'h31 : 32'h0, q);
        end
    endtask
    task automatic t_error();
        @(posedge clk_sys);
        module_error <= 1'b1;
        @(posedge clk_sys);
        module_error <= 1'b0;
        rd(OFS_STATUS);
        chk("ready_low", 32'h0, module_ready);
        chk("st_ready", 32'h0, 32'(q[ST_READY_BIT]));
    endtask

    task automatic close_out();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // reset, then each scenario
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_preset();
        t_bad_axis();
        t_clear();
        t_float();
        t_aux();
        t_error();
        close_out();
    end
endmodule // aach_axis_aux_command_handler_bench

// File: verification/aach_ctrl_model.sv
// Purpose: controller model issuing register accesses and commands
// Assumes: Avalon-MM slave with waitrequest on clk_sys
// Notes:   released address and data lines show inverted values; read and write go low
`timescale 1ns/10ps
module aach_ctrl_model
    import aach_pkg::*;
(
    input  wire logic              clk_sys,
    output logic      [ADDR_W-1:0] avs_address,
    output logic                   avs_read,
    output logic                   avs_write,
    output logic      [31:0]       avs_writedata,
    input  wire logic [31:0]       avs_readdata,
    input  wire logic              avs_waitrequest
);
    // idle bus at time zero
    initial begin
        avs_address   = '0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = '0;
    end

    // one access, held until waitrequest is low at a rising edge
    task automatic xfer(input logic wr, input logic [9:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask

    // command, then poll status till idle
    task automatic cmd(input logic [31:0] w);
        logic [31:0] q;
        xfer(1'b1, OFS_CMD, w, q);
        do xfer(1'b0, OFS_STATUS, ZERO32, q);
        while (q[ST_BUSY_BIT] !== 1'b0);
    endtask
endmodule // aach_ctrl_model
